// *** core/timer_pkg.sv ***
`default_nettype none

package timer_pkg;

  // ****************************************************
  // Register map: printed offsets are word indices.
  // ****************************************************
  localparam logic [7:0] MODE_IDX = 8'hd8;
  localparam logic [7:0] COUNT_IDX = 8'hd9;
  localparam logic [7:0] STATUS_IDX = 8'he0;
  localparam logic [7:0] MASK_IDX = 8'he1;
  localparam int ADDR_W = 10;

  // ****************************************************
  // Field positions and values after reset.
  // ****************************************************
  localparam int RUN_BIT = 7;
  localparam int PRESCALE_LSB = 4;
  localparam int RTC_SEL_BIT = 0;
  localparam int OVF_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [7:0] COUNT_TOP = 8'hff;

  // ****************************************************
  // Timing of the real-time source.
  // ****************************************************
  localparam int MCLK_HZ = 100_000_000;
  localparam int RTC_HZ = 32768;
  localparam int RTC_INTERVAL_MS = 500;
  localparam int COUNT_STEPS = 256;
  localparam int RTC_DIV = RTC_HZ * RTC_INTERVAL_MS / 1000 / COUNT_STEPS;
  localparam int RTC_DIV_W = $clog2(RTC_DIV);

endpackage : timer_pkg

`default_nettype wire

// *** core/tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Carries the timer setup to the step generator and the step back.
interface tick_if;
  logic run;
  logic [2:0] prescale_select;
  logic rtc_source_select;
  logic tick;
  modport src (input run, input prescale_select,
               input rtc_source_select, output tick);
  modport sink (output run, output prescale_select,
                output rtc_source_select, input tick);
endinterface : tick_if

`default_nettype wire

// *** core/tick_source.sv ***
`timescale 1ns/1ps
`default_nettype none

module tick_source
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rtc_clk,
  input wire logic rtc_allowed,
  tick_if.src tk
);

  logic rtc_meta_r;
  logic rtc_sync_r;
  logic rtc_last_r;
  logic [7:0] div_r;
  logic [RTC_DIV_W-1:0] rtc_div_r;
  logic [7:0] div_mask;
  logic rtc_edge;
  logic pre_tick;
  logic rtc_tick;
  logic rtc_mode;

  // Two flip-flops bring the slow pin into mclk; a third finds edges.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_meta_r <= 1'b0;
      rtc_sync_r <= 1'b0;
      rtc_last_r <= 1'b0;
    end else if (ce) begin
      rtc_meta_r <= rtc_clk;
      rtc_sync_r <= rtc_meta_r;
      rtc_last_r <= rtc_sync_r;
    end
  end

  assign rtc_edge = rtc_sync_r & ~rtc_last_r;
  assign rtc_mode = tk.rtc_source_select & rtc_allowed;

  // Prescaler: divisor 256 at code zero, halved for each higher code.
  // divisor from code
  assign div_mask = 8'hff >> tk.prescale_select;
  assign pre_tick = tk.run & ((div_r & div_mask) == div_mask);

  // The divider runs only while the timer runs, so each start is clean.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 8'h00;
    end else if (ce) begin
      div_r <= tk.run ? div_r + 8'h01 : 8'h00;
    end
  end

  // The real-time edges are divided so 256 steps last half a second.
  // fixed rtc interval
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_div_r <= '0;
    end else if (ce && tk.run && rtc_mode && rtc_edge) begin
      rtc_div_r <= rtc_div_r + RTC_DIV_W'(1);
    end
  end

  assign rtc_tick = tk.run & rtc_edge & (&rtc_div_r);

  assign tk.tick = rtc_mode ? rtc_tick :
                   (tk.rtc_source_select ? 1'b0 : pre_tick);

  // Fastest prescale code gives a step every second enabled cycle.
  // divide by two
  div_two_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tk.tick && !tk.rtc_source_select && tk.prescale_select == 3'h7
     && ce)
    ##1 (ce && !tk.rtc_source_select && tk.prescale_select == 3'h7
         && tk.run)
    ##1 (!tk.rtc_source_select && tk.prescale_select == 3'h7 && tk.run)
    |-> tk.tick && !$past(tk.tick))
    else $error("prescale code 7 does not step every second cycle");

endmodule : tick_source

`default_nettype wire

// *** core/interval_timer.sv ***
// Overview of operation
// - Count up in eight bits; wrap from top to zero raises an overflow.
// - Count only while the run bit, mode bit 7, is one.
// - Mode bit 0 chooses prescaled cpu clock or the real-time source.
// - Prescale bits 6 to 4 divide by 256 at code 0, 2 at code 7.
// - Real-time mode ignores prescale; 256 steps take half a second.
// - Real-time source works only when the build option allows it.
// - An overflow during light sleep with the timer running wakes the system.
// - The count register reads and writes the live count.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module interval_timer
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rtc_clk,
  input wire logic rtc_option,
  input wire logic light_sleep,
  output logic irq,
  output logic wake_up
);

  // ****************************************************
  // Declarations.
  // ****************************************************
  logic rst_meta_r;
  logic rst_n_sync;
  logic opt_meta_r;
  logic opt_sync_r;
  logic opt_taken_r;
  logic [1:0] opt_age_r;
  logic rtc_allowed_r;
  logic ack_r;
  logic timer_run_enable_r;
  logic [2:0] prescale_select_r;
  logic rtc_source_select_r;
  logic [7:0] count_value_r;
  logic [7:0] count_value_nxt;
  logic overflow_request_flag_r;
  logic overflow_irq_enable_r;
  logic wake_up_r;
  logic [31:0] readdata_r;
  logic [7:0] reg_idx;
  logic wr_accept;
  logic rd_accept;
  logic wr_low;
  logic wr_mode;
  logic wr_count;
  logic wr_status;
  logic wr_mask;
  logic step;
  logic overflow;
  logic [7:0] mode_view;

  tick_if tk ();

  // ****************************************************
  // Reset release.
  // ****************************************************

  // The reset is asserted at once and released through two flip-flops.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_sync <= rst_meta_r;
    end
  end

  // ****************************************************
  // Build option strap.
  // ****************************************************

  // The strap pin is synchronised before anything looks at it.
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      opt_meta_r <= 1'b0;
      opt_sync_r <= 1'b0;
    end else if (ce) begin
      opt_meta_r <= rtc_option;
      opt_sync_r <= opt_meta_r;
    end
  end

  // The option is caught once, when the synchroniser has filled, then held.
  // option capture
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      opt_taken_r <= 1'b0;
      opt_age_r <= 2'h0;
      rtc_allowed_r <= 1'b0;
    end else if (ce && !opt_taken_r) begin
      opt_age_r <= {opt_age_r[0], 1'b1};
      if (opt_age_r[1]) begin
        opt_taken_r <= 1'b1;
        rtc_allowed_r <= opt_sync_r;
      end
    end
  end

  // ****************************************************
  // Avalon-MM slave.
  // ****************************************************

  // Every access waits one cycle; the answer comes from a flip-flop.
  assign waitrequest = (read | write) & ~(ack_r & ce);
  assign reg_idx = address[ADDR_W-1:2];
  assign wr_accept = write & ack_r & ce;
  assign rd_accept = read & ~ack_r & ce;
  assign wr_low = wr_accept & byteenable[0];
  assign wr_mode = wr_low & (reg_idx == MODE_IDX);
  assign wr_count = wr_low & (reg_idx == COUNT_IDX);
  assign wr_status = wr_low & (reg_idx == STATUS_IDX);
  assign wr_mask = wr_low & (reg_idx == MASK_IDX);

  // The acknowledge flop ends the wait one cycle after the request.
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  // Reserved mode bits read as zero.
  assign mode_view = {timer_run_enable_r, prescale_select_r, 3'h0,
                      rtc_source_select_r};

  // Read data is latched when the wait is released; unmapped reads zero.
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      readdata_r <= 32'h0000_0000;
    end else if (rd_accept) begin
      unique case (reg_idx)
        MODE_IDX: readdata_r <= {24'h00_0000, mode_view};
        COUNT_IDX: readdata_r <= {24'h00_0000, count_value_r};
        STATUS_IDX: readdata_r <= {31'h0, overflow_request_flag_r};
        MASK_IDX: readdata_r <= {31'h0, overflow_irq_enable_r};
        default: readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign readdata = readdata_r;

  // ****************************************************
  // Mode register.
  // ****************************************************

  // Software writes run, prescale and source select in one word.
  // mode reset
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      timer_run_enable_r <= MODE_RESET[RUN_BIT];
      prescale_select_r <= PRESCALE_RESET;
      rtc_source_select_r <= MODE_RESET[RTC_SEL_BIT];
    end else if (wr_mode) begin
      timer_run_enable_r <= writedata[RUN_BIT];
      prescale_select_r <= writedata[PRESCALE_LSB +: 3];
      rtc_source_select_r <= writedata[RTC_SEL_BIT];
    end
  end

  // ****************************************************
  // Step generator.
  // ****************************************************

  assign tk.run = timer_run_enable_r;
  assign tk.prescale_select = prescale_select_r;
  assign tk.rtc_source_select = rtc_source_select_r;

  tick_source u_tick_source (
    .mclk(mclk),
    .rst_n(rst_n_sync),
    .ce(ce),
    .rtc_clk(rtc_clk),
    .rtc_allowed(rtc_allowed_r),
    .tk(tk.src)
  );

  // ****************************************************
  // Counter.
  // ****************************************************

  assign step = tk.tick & timer_run_enable_r & ce;
  assign overflow = step & (count_value_r == COUNT_TOP) & ~wr_count;

  // A software load wins over a step in the same cycle.
  // load the count
  always_comb begin
    count_value_nxt = count_value_r;
    if (wr_count) begin
      count_value_nxt = writedata[7:0];
    end else if (step) begin
      count_value_nxt = count_value_r + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      count_value_r <= COUNT_RESET;
    end else if (ce) begin
      count_value_r <= count_value_nxt;
    end
  end

  // ****************************************************
  // Interrupt status and mask.
  // ****************************************************

  // The flag is cleared by writing one; a new overflow wins the cycle.
  // sticky flag
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      overflow_request_flag_r <= 1'b0;
    end else if (overflow) begin
      overflow_request_flag_r <= 1'b1;
    end else if (wr_status && writedata[OVF_BIT]) begin
      overflow_request_flag_r <= 1'b0;
    end
  end

  // The mask bit is the interrupt enable.
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      overflow_irq_enable_r <= 1'b0;
    end else if (wr_mask) begin
      overflow_irq_enable_r <= writedata[OVF_BIT];
    end
  end

  assign irq = overflow_request_flag_r & overflow_irq_enable_r;

  // ****************************************************
  // Light-sleep wake.
  // ****************************************************

  // One-cycle wake pulse on an overflow while the core sleeps.
  // wake on overflow
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      wake_up_r <= 1'b0;
    end else if (ce) begin
      wake_up_r <= overflow & light_sleep;
    end
  end

  assign wake_up = wake_up_r;

  // ****************************************************
  // Checks.
  // ****************************************************

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n_sync);

  overflow_flag_a: assert property (
    (step && count_value_r == COUNT_TOP && !wr_count)
    |=> overflow_request_flag_r && count_value_r == 8'h00)
    else $error("wrap did not set the flag or reach zero");

  stop_hold_a: assert property (
    (!timer_run_enable_r && !wr_count) |=> $stable(count_value_r))
    else $error("count moved while the timer was stopped");

  source_pick_a: assert property (
    (rtc_source_select_r && !rtc_allowed_r) |-> !tk.tick)
    else $error("step seen with unavailable real-time source");

  count_load_a: assert property (
    wr_count |=> count_value_r == $past(writedata[7:0]))
    else $error("count write not taken");

  flag_sticky_a: assert property (
    (overflow_request_flag_r && !(wr_status && writedata[OVF_BIT]))
    |=> overflow_request_flag_r)
    else $error("overflow flag dropped without a clear");

  irq_gate_a: assert property (
    (wr_status && writedata[OVF_BIT] && !overflow) |=> !irq)
    else $error("interrupt still high after the flag was cleared");

  wake_pulse_a: assert property (
    (overflow && light_sleep) |=> wake_up ##1 (!wake_up || !$past(ce) ||
      $past(overflow)))
    else $error("wake pulse missing or too long");

  reset_zero_a: assert property (
    $rose(rst_n_sync) |-> (count_value_r == 8'h00 && mode_view == 8'h00))
    else $error("timer not zero after reset");

  // Bus answer comes one cycle after the request.
  bus_wait_a: assert property (
    ((read || write) && !ack_r && ce) |-> waitrequest ##1
      (waitrequest == !ce))
    else $error("waitrequest not released after one cycle");

  // Nothing moves while the clock enable is low.
  ce_freeze_a: assert property (
    !ce |=> $stable(count_value_r) && $stable(mode_view)
      && $stable(overflow_request_flag_r))
    else $error("state changed while the clock enable was low");

  mode_write_a: assert property (
    wr_mode |=> timer_run_enable_r == $past(writedata[RUN_BIT])
      && rtc_source_select_r == $past(writedata[RTC_SEL_BIT]))
    else $error("mode write not taken");

  clear_win_a: assert property (
    (overflow && wr_status && writedata[OVF_BIT]) |=> overflow_request_flag_r)
    else $error("clear in the overflow cycle dropped the flag");

endmodule : interval_timer

`default_nettype wire

// *** testbench/tb_interval_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_interval_timer
  import timer_pkg::*;
;
  // ****************************************************
  // Stimulus signals and the block under test.
  // ****************************************************
  logic mclk;
  logic resetn;
  logic ce;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic rtc_clk;
  logic rtc_option;
  logic light_sleep;
  logic irq;
  logic wake_up;
  logic [7:0] rd;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int wakes = 0;

  interval_timer dut_u (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .rtc_clk(rtc_clk),
    .rtc_option(rtc_option),
    .light_sleep(light_sleep),
    .irq(irq),
    .wake_up(wake_up)
  );

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Counts wake pulses at the falling edge, where they are settled.
  always @(negedge mclk) begin
    if (wake_up === 1'b1) wakes++;
  end

  // Cuts a hang short after a cycle ceiling.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************************
  // Shared tasks.
  // ****************************************************
  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask : cycles

  // One bus cycle; the request holds until a rising edge sees no wait.
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] be);
    @(posedge mclk);
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    rd = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx);
    bus(1'b0, idx, 8'h00, 4'h1);
  endtask : rd_reg

  task automatic do_reset();
    resetn <= 1'b0;
    cycles(5);
    resetn <= 1'b1;
    cycles(8);
  endtask : do_reset

  // The real-time pin runs at a fast bench rate to keep the run short.
  task automatic rtc_edges(input int n);
    repeat (n) begin
      rtc_clk <= 1'b1;
      cycles(10);
      rtc_clk <= 1'b0;
      cycles(10);
    end
  endtask : rtc_edges

  // ****************************************************
  // Scenarios.
  // ****************************************************
  task automatic t_regs();
    logic [7:0] idxs [5];
    idxs = '{MODE_IDX, COUNT_IDX, STATUS_IDX, MASK_IDX, 8'h10};
    foreach (idxs[i]) begin
      rd_reg(idxs[i]);
      check(rd, 8'h00);
    end
    @(negedge mclk);
    check({7'h0, irq}, 8'h00);
  endtask : t_regs

  task automatic t_mode_rw();
    wr_reg(MODE_IDX, 8'hff);
    rd_reg(MODE_IDX);
    check(rd, 8'hf1);
    bus(1'b1, MODE_IDX, 8'h00, 4'h0);
    rd_reg(MODE_IDX);
    check(rd, 8'hf1);
    wr_reg(MODE_IDX, 8'h00);
    wr_reg(COUNT_IDX, 8'h5a);
    rd_reg(COUNT_IDX);
    check(rd, 8'h5a);
  endtask : t_mode_rw

  task automatic prescale_sweep();
    int div;
    for (int p = 0; p < 8; p++) begin
      div = 256 >> p;
      wr_reg(MODE_IDX, 8'h00);
      wr_reg(COUNT_IDX, 8'h00);
      wr_reg(MODE_IDX, {1'b1, 3'(p), 4'h0});
      cycles(3 * div + div / 2 - 2);
      rd_reg(COUNT_IDX);
      check(rd, 8'h03);
    end
  endtask : prescale_sweep

  task automatic t_overflow_irq();
    // stop, mask and clear before the setup.
    wr_reg(MODE_IDX, 8'h00);
    wr_reg(MASK_IDX, 8'h00);
    wr_reg(STATUS_IDX, 8'h01);
    wr_reg(COUNT_IDX, 8'hff);
    wakes = 0;
    wr_reg(MODE_IDX, 8'hf0);
    cycles(20);
    // wrap sets the sticky flag and counting goes on.
    rd_reg(STATUS_IDX);
    check(rd, 8'h01);
    rd_reg(COUNT_IDX);
    check({7'h0, rd < 8'h20}, 8'h01);
    @(negedge mclk);
    check({7'h0, irq}, 8'h00);
    wr_reg(MASK_IDX, 8'h01);
    @(negedge mclk);
    check({7'h0, irq}, 8'h01);
    wr_reg(MODE_IDX, 8'h00);
    wr_reg(STATUS_IDX, 8'h00);
    rd_reg(STATUS_IDX);
    check(rd, 8'h01);
    wr_reg(STATUS_IDX, 8'h01);
    rd_reg(STATUS_IDX);
    check(rd, 8'h00);
    @(negedge mclk);
    check({7'h0, irq}, 8'h00);
    check(8'(wakes), 8'h00);
  endtask : t_overflow_irq

  task automatic t_run_hold();
    wr_reg(COUNT_IDX, 8'h10);
    wr_reg(MODE_IDX, 8'h70);
    cycles(50);
    rd_reg(COUNT_IDX);
    check(rd, 8'h10);
  endtask : t_run_hold

  // A low clock enable holds the count although the timer runs.
  task automatic t_ce_freeze();
    wr_reg(MODE_IDX, 8'h00);
    wr_reg(COUNT_IDX, 8'h40);
    wr_reg(MODE_IDX, 8'hf0);
    ce <= 1'b0;
    cycles(50);
    ce <= 1'b1;
    rd_reg(COUNT_IDX);
    check(rd, 8'h40);
    wr_reg(MODE_IDX, 8'h00);
  endtask : t_ce_freeze

  task automatic t_wake();
    light_sleep <= 1'b1;
    wr_reg(MODE_IDX, 8'h00);
    wr_reg(COUNT_IDX, 8'hff);
    wakes = 0;
    wr_reg(MODE_IDX, 8'hf0);
    cycles(20);
    check(8'(wakes), 8'h01);
    wr_reg(MODE_IDX, 8'h00);
    light_sleep <= 1'b0;
  endtask : t_wake

  // The count is loaded while stopped, never in real-time mode.
  task automatic t_rtc();
    wr_reg(STATUS_IDX, 8'h01);
    // count loaded before real-time mode starts.
    wr_reg(COUNT_IDX, 8'hfe);
    wr_reg(MODE_IDX, 8'hf1);
    rtc_edges(96);
    // read the count once, one step before the wrap.
    rd_reg(COUNT_IDX);
    check(rd, 8'hff);
    rtc_edges(64);
    rd_reg(COUNT_IDX);
    check(rd, 8'h00);
    rd_reg(STATUS_IDX);
    check(rd, 8'h01);
    // wait half a real-time period before the clear.
    cycles(10);
    wr_reg(STATUS_IDX, 8'h01);
    rd_reg(STATUS_IDX);
    check(rd, 8'h00);
  endtask : t_rtc

  task automatic t_rtc_blocked();
    wr_reg(COUNT_IDX, 8'h20);
    wr_reg(MODE_IDX, 8'hf1);
    rtc_edges(140);
    rd_reg(COUNT_IDX);
    check(rd, 8'h20);
  endtask : t_rtc_blocked

  // Main sequence; the second reset lands with the timer running.
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    byteenable = 4'h0;
    writedata = 32'h0;
    rtc_clk = 1'b0;
    rtc_option = 1'b1;
    light_sleep = 1'b0;
    do_reset();
    t_regs();
    t_mode_rw();
    prescale_sweep();
    t_overflow_irq();
    t_run_hold();
    t_ce_freeze();
    t_wake();
    t_rtc();
    rtc_option <= 1'b0;
    do_reset();
    t_regs();
    t_rtc_blocked();
    end_sim();
  end
endmodule : tb_interval_timer

`default_nettype wire
